// ==== itm_timer.sv ====
// Interval and square wave timer with its AXI4-Lite register slave
//
// Summary of operation
// - Selection 000 full clock, 001 /4, 100 /2, 101 /8, 110 /16.
// - Selection 010 uses watch tick, 011 external edges; 111 prohibited.
// - Mode bits 11 start clear-on-compare counting on the count clock.
// - Counter equal to compare_reg0 raises compare0_irq, and clears it in mode 11 only.
// - Compare value M gives M plus one count periods between interrupts.
// - compare1_irq fires on compare_reg1 match; software masks it if unused.
// - Reading the counter returns its value without disturbing counting.
// - Mode bits 00 stop counting and reset the counter.
// - Each compare_reg0 match interrupts and toggles timer_out, and clears the counter in mode 11 only.
// - out_enable low holds timer_out low; high lets the flip-flop drive.
// - toggle_on_cmp0 enables toggling; compare0_irq still fires without it.
// - Square wave period is twice (M plus one) count periods.
`timescale 1ns/100ps
`default_nettype none
module itm_timer import itm_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watch_tick,
  input wire logic ext_event_in,
  output logic timer_out,
  output logic compare0_irq,
  output logic compare1_irq
);

  itm_regs_t st;
  itm_regs_t next_st;
  logic count_tick;
  logic wr_do;
  logic match0;
  logic match1;
  logic [31:0] wval;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_COUNTER, OFS_CMP0, OFS_CMP1, OFS_MODE, OFS_CAPCMP, OFS_OUTCTL,
      OFS_PRESCALE, OFS_CLKSEL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a,
                                          input itm_regs_t s);
    logic [31:0] w;
    w = '0;
    case (a)
      OFS_COUNTER: w[15:0] = s.counter;
      OFS_CMP0: w[15:0] = s.cr0;
      OFS_CMP1: w[15:0] = s.cr1;
      OFS_MODE: w[MODE_MSB:MODE_LSB] = s.mode;
      OFS_CAPCMP: w[CRC_MSB:0] = s.crc;
      OFS_OUTCTL: begin
        // Level set and reset triggers always read back as zero
        w[TOC_OE_BIT] = s.toc_oe;
        w[TOC_CMP0_BIT] = s.toc_cmp0;
        w[TOC_CMP1_BIT] = s.toc_cmp1;
      end
      OFS_PRESCALE: w[7:0] = s.prm;
      OFS_CLKSEL: w[ISEL_BIT] = s.isel;
      default: w = '0;
    endcase
    rd_word = w;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    wmerge = r;
  endfunction

  // ---------------------------------------------------------------
  // Count clock selection
  // ---------------------------------------------------------------
  itm_clk_sel i_itm_clk_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel({st.isel, st.prm[PRM_SEL_MSB:PRM_SEL_LSB]}),
    .edge_sel(st.prm[PRM_ES0_MSB:PRM_ES0_LSB]),
    .watch_tick(watch_tick),
    .ext_event_in(ext_event_in),
    .count_tick(count_tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.irq0 = 1'b0;
    next_st.irq1 = 1'b0;
    match0 = (st.counter == st.cr0);
    match1 = (st.counter == st.cr1);
    wr_do = st.aw_have && st.w_have;
    wval = wmerge(rd_word(st.waddr, st), st.wdata, st.wstrb);

    // stopped counter sits at its initial value
    if (st.mode == MODE_STOP) begin
      next_st.counter = CNT_INIT;
    end else if (count_tick) begin
      // second compare raises its request in every running mode
      if (match1) begin
        next_st.irq1 = 1'b1;
      end
      // match interrupts, and clears in mode 11; giving M plus one periods
      if (match0) begin
        next_st.irq0 = 1'b1;
      end
      if ((st.mode == MODE_CLR_CMP) && match0) begin
        next_st.counter = CNT_INIT;
      end else begin
        next_st.counter = st.counter + CNT_STEP;
      end
      // invert output; gated by toggle_on_cmp0, or by toc_cmp1 for a compare1 match; half period
      next_st.out_ff = st.out_ff ^ ((match0 && st.toc_cmp0)
                                    || (match1 && st.toc_cmp1));
    end

    // Address and data are taken independently; the write waits for both
    if (s_axi_awvalid && st.awready) begin
      next_st.awready = 1'b0;
      next_st.aw_have = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.wready = 1'b0;
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (wr_do) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.waddr) ? RESP_OKAY : RESP_SLVERR;
      // Register writes come last so software wins over the count
      case (st.waddr)
        OFS_CMP0: next_st.cr0 = wval[15:0];
        OFS_CMP1: next_st.cr1 = wval[15:0];
        OFS_MODE: begin
          // mode 11 starts counting from the cleared counter
          next_st.mode = wval[MODE_MSB:MODE_LSB];
          // writing 00 stops and reinitialises at once
          if (wval[MODE_MSB:MODE_LSB] == MODE_STOP) begin
            next_st.counter = CNT_INIT;
          end
        end
        OFS_CAPCMP: next_st.crc = wval[CRC_MSB:0];
        OFS_OUTCTL: begin
          next_st.toc_oe = wval[TOC_OE_BIT];
          next_st.toc_cmp0 = wval[TOC_CMP0_BIT];
          next_st.toc_cmp1 = wval[TOC_CMP1_BIT];
          // Both triggers together are prohibited and leave the level alone
          if (wval[TOC_LVS_BIT] && !wval[TOC_LVR_BIT]) begin
            next_st.out_ff = 1'b1;
          end else if (wval[TOC_LVR_BIT] && !wval[TOC_LVS_BIT]) begin
            next_st.out_ff = 1'b0;
          end
        end
        OFS_PRESCALE: next_st.prm = wval[7:0] & PRM_MASK;
        OFS_CLKSEL: next_st.isel = wval[ISEL_BIT];
        default: next_st.mode = next_st.mode;
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // a read only samples the counter, it never alters it
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word(s_axi_araddr, st);
      next_st.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // pin held low unless the output is enabled
    next_st.timer_out = next_st.toc_oe && next_st.out_ff;

    if (!aresetn) begin
      next_st = '0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign timer_out = st.timer_out;
  assign compare0_irq = st.irq0;
  assign compare1_irq = st.irq1;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  clear_on_match_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st.mode == MODE_CLR_CMP) && count_tick && match0 && !wr_do
      |=> (st.counter == CNT_INIT) && compare0_irq)
    else $error("Compare match did not clear and interrupt");
  irq1_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.mode != MODE_STOP) && count_tick && match1 |=> compare1_irq)
    else $error("Second compare match gave no request");
  irq0_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    compare0_irq |-> $past(count_tick) && $past(match0))
    else $error("Compare interrupt without a match");
  stop_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.mode == MODE_STOP) |=> (st.counter == CNT_INIT))
    else $error("Stopped counter not at initial value");
  count_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.mode != MODE_STOP) && count_tick && !wr_do
      && !((st.mode == MODE_CLR_CMP) && match0)
      |=> (st.counter == $past(st.counter) + CNT_STEP))
    else $error("Counter did not step by one");
  out_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.toc_oe |-> !timer_out)
    else $error("Timer output high while disabled");
  toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.mode == MODE_CLR_CMP) && count_tick && match0 && !match1
      && st.toc_cmp0 && st.toc_oe && !wr_do
      |=> (timer_out != $past(timer_out)))
    else $error("Square wave output did not invert on match");
  no_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.toc_cmp0 && !st.toc_cmp1 && !wr_do |=> $stable(st.out_ff))
    else $error("Output inverted with toggling disabled");
  read_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && st.arready && (s_axi_araddr == OFS_COUNTER)
      |=> s_axi_rvalid && (s_axi_rdata[15:0] == $past(st.counter)))
    else $error("Counter read returned a wrong value");
  start_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.mode == MODE_STOP) ##1 (st.mode == MODE_CLR_CMP)
      |-> (st.counter == CNT_INIT))
    else $error("Counting did not start from a cleared counter");
  irq0_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.mode != MODE_STOP) && count_tick && match0 && !st.toc_cmp0
      |=> compare0_irq)
    else $error("Compare interrupt lost with toggling disabled");
  stop_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && (st.waddr == OFS_MODE) && (wval[MODE_MSB:MODE_LSB] == MODE_STOP)
      |=> (st.counter == CNT_INIT) && (st.mode == MODE_STOP))
    else $error("Writing stop did not clear the counter");
  irq1_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    compare1_irq |-> $past(count_tick) && $past(match1))
    else $error("Second compare request without a match");
  out_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.toc_oe |-> (timer_out == st.out_ff))
    else $error("Enabled output does not follow its flip-flop");

endmodule
`default_nettype wire

// ==== itm_pkg.sv ====
// Constants, register map and state types for the interval square wave timer
package itm_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CMP0 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP1 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_CAPCMP = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_OUTCTL = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CLKSEL = 6'h1c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_LSB = 2;
  localparam int MODE_MSB = 3;
  localparam int CRC_MSB = 2;
  localparam int TOC_OE_BIT = 0;
  localparam int TOC_CMP0_BIT = 1;
  localparam int TOC_LVR_BIT = 2;
  localparam int TOC_LVS_BIT = 3;
  localparam int TOC_CMP1_BIT = 4;
  localparam int PRM_SEL_LSB = 0;
  localparam int PRM_SEL_MSB = 1;
  localparam int PRM_ES0_LSB = 4;
  localparam int PRM_ES0_MSB = 5;
  localparam int ISEL_BIT = 1;
  localparam logic [7:0] PRM_MASK = 8'hf3;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_CLR_CMP = 2'h3;
  localparam logic [15:0] CNT_INIT = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [1:0] ES_FALL = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Count clock selection: {input_select_hi, prescale_sel1, prescale_sel0}
  localparam logic [2:0] CS_FULL = 3'h0;
  localparam logic [2:0] CS_DIV4 = 3'h1;
  localparam logic [2:0] CS_WATCH = 3'h2;
  localparam logic [2:0] CS_EXT = 3'h3;
  localparam logic [2:0] CS_DIV2 = 3'h4;
  localparam logic [2:0] CS_DIV8 = 3'h5;
  localparam logic [2:0] CS_DIV16 = 3'h6;
  localparam logic [2:0] CS_BAD = 3'h7;
  localparam logic [3:0] DIV2_MASK = 4'h1;
  localparam logic [3:0] DIV4_MASK = 4'h3;
  localparam logic [3:0] DIV8_MASK = 4'h7;
  localparam logic [3:0] DIV16_MASK = 4'hf;

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [15:0] counter;
    logic [15:0] cr0;
    logic [15:0] cr1;
    logic [1:0] mode;
    logic [CRC_MSB:0] crc;
    logic toc_oe;
    logic toc_cmp0;
    logic toc_cmp1;
    logic out_ff;
    logic [7:0] prm;
    logic isel;
    logic timer_out;
    logic irq0;
    logic irq1;
  } itm_regs_t;

  typedef struct packed {
    logic [3:0] div;
    logic smp0;
    logic smp1;
    logic lvl;
    logic tick;
  } itm_sel_t;

endpackage

// ==== itm_clk_sel.sv ====
// Count clock selector: prescaler taps, watch tick and filtered edge input
`timescale 1ns/100ps
`default_nettype none
module itm_clk_sel import itm_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] sel,
  input wire logic [1:0] edge_sel,
  input wire logic watch_tick,
  input wire logic ext_event_in,
  output logic count_tick
);

  itm_sel_t st;
  itm_sel_t next_st;
  logic rise;
  logic fall;

  function automatic logic tap(input logic [3:0] div, input logic [3:0] m);
    tap = ((div & m) == m);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.div = st.div + 4'h1;
    next_st.smp0 = ext_event_in;
    next_st.smp1 = st.smp0;
    // A level counts only after two equal samples, so short glitches vanish
    if (st.smp0 == st.smp1) begin
      next_st.lvl = st.smp1;
    end
    rise = !st.lvl && next_st.lvl;
    fall = st.lvl && !next_st.lvl;
    case (sel)
      CS_FULL: next_st.tick = 1'b1;
      CS_DIV2: next_st.tick = tap(st.div, DIV2_MASK);
      CS_DIV4: next_st.tick = tap(st.div, DIV4_MASK);
      CS_DIV8: next_st.tick = tap(st.div, DIV8_MASK);
      CS_DIV16: next_st.tick = tap(st.div, DIV16_MASK);
      CS_WATCH: next_st.tick = watch_tick;
      CS_EXT: begin
        case (edge_sel)
          ES_FALL: next_st.tick = fall;
          ES_RISE: next_st.tick = rise;
          ES_BOTH: next_st.tick = rise | fall;
          default: next_st.tick = 1'b0;
        endcase
      end
      default: next_st.tick = 1'b0;
    endcase
    if (!aresetn) begin
      next_st = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign count_tick = st.tick;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  full_rate_tick_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (sel == CS_FULL) |=> count_tick)
    else $error("Full rate selection did not tick");
  div4_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel == CS_DIV4) [*4] |-> ##1 $past(count_tick, 1) || $past(count_tick, 2)
      || $past(count_tick, 3) || count_tick)
    else $error("Divide by four gave no tick in four cycles");
  bad_sel_quiet_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (sel == CS_BAD) |=> !count_tick)
    else $error("Prohibited selection produced a tick");

endmodule
`default_nettype wire

// ==== itm_timer_test.sv ====
// Self-checking testbench for the interval square wave timer
`timescale 1ns/100ps
`default_nettype none
module itm_timer_test import itm_pkg::*;;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic watch_tick = 1'b0;
  logic ext_event_in = 1'b0;
  logic run_src = 1'b0;
  logic timer_out, compare0_irq, compare1_irq;
  logic [3:0] src_cnt = 4'h0;
  int cyc = 0;
  int ar_cyc = 0;
  int fails = 0;
  int n_compared = 0;

  itm_timer i_itm_timer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .watch_tick, .ext_event_in, .timer_out, .compare0_irq,
    .compare1_irq
  );

  // ---------------------------------------------------------------
  // Clock, watchdog and count sources
  // ---------------------------------------------------------------
  always #50 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  // Watch tick every 10 cycles and ext input moves, both only while enabled
  always @(posedge aclk) begin
    src_cnt <= (src_cnt == 4'h9) ? 4'h0 : src_cnt + 4'h1;
    watch_tick <= run_src && src_cnt == 4'h0;
    if (run_src && src_cnt == 4'h9) begin
      ext_event_in <= ~ext_event_in;
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit ap;
    bit wp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    for (int n = 0; n < 100 && (ap || wp); n++) begin
      @(posedge aclk);
      if (ap && s_axi_awready === 1'b1) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready === 1'b1) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) break;
    end
    ar_cyc = cyc;
    s_axi_arvalid <= 1'b0;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic set(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("write response", r, RESP_OKAY);
  endtask

  // Stop, configure clock, compare0 and output, then start: the order software must keep
  task automatic start(input logic [2:0] cs, input logic [7:0] es,
                       input logic [15:0] m, input logic [7:0] oc);
    set(OFS_MODE, 32'h0);
    set(OFS_PRESCALE, {24'h0, es | {6'h0, cs[1:0]}});
    set(OFS_CLKSEL, {30'h0, cs[2], 1'b0});
    set(OFS_CMP0, {16'h0, m});
    set(OFS_OUTCTL, {24'h0, oc});
    set(OFS_MODE, {28'h0, MODE_CLR_CMP, 2'h0});
  endtask

  task automatic wait_irq(input bit sel1, output int t);
    for (int n = 0; n < 2000; n++) begin
      @(negedge aclk);
      if ((sel1 ? compare1_irq : compare0_irq) === 1'b1) break;
    end
    t = cyc;
  endtask

  // First pulse is skipped: start-up phase of the tick source varies
  task automatic period(input bit sel1, input int exp, input string what);
    int t0;
    int t1;
    int t2;
    wait_irq(sel1, t0);
    wait_irq(sel1, t1);
    wait_irq(sel1, t2);
    check(what, t2 - t1, exp);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [ADDR_W-1:0] ofs [8] = '{OFS_COUNTER, OFS_CMP0, OFS_CMP1, OFS_MODE,
      OFS_CAPCMP, OFS_OUTCTL, OFS_PRESCALE, OFS_CLKSEL};
    logic [31:0] d;
    logic [1:0] r;
    check("out after reset", timer_out, 1'b0);
    check("irq after reset", {compare1_irq, compare0_irq}, 2'h0);
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], d, r);
      check("reset value", d, 32'h0);
    end
    rd(6'h20, d, r);
    check("unmapped read resp", r, RESP_SLVERR);
    check("unmapped read data", d, 32'h0);
    wr(6'h24, 32'h1, r);
    check("unmapped write resp", r, RESP_SLVERR);
    set(OFS_COUNTER, 32'h1234);
    rd(OFS_COUNTER, d, r);
    check("counter read only", d, 32'h0);
    set(OFS_CMP1, 32'h0001abcd);
    rd(OFS_CMP1, d, r);
    check("cmp1 width", d, 32'h0000abcd);
    set(OFS_PRESCALE, 32'hff);
    rd(OFS_PRESCALE, d, r);
    check("prescale bits", d, {24'h0, PRM_MASK});
    $display("Test regs done");
  endtask

  task automatic t_clocks;
    logic [2:0] cs [5] = '{CS_FULL, CS_DIV4, CS_DIV2, CS_DIV8, CS_DIV16};
    int dv [5] = '{1, 4, 2, 8, 16};
    for (int i = 0; i < 5; i++) begin
      start(cs[i], 8'h00, 16'h0004, 8'h00);
      period(1'b0, 5 * dv[i], "divided interval");
    end
    $display("Test clocks done");
  endtask

  task automatic t_sources;
    logic [7:0] es [3] = '{8'h00, 8'h10, 8'h30};
    int ep [3] = '{20, 20, 10};
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    run_src <= 1'b1;
    start(CS_WATCH, 8'h00, 16'h0002, 8'h00);
    period(1'b0, 30, "watch interval");
    for (int i = 0; i < 3; i++) begin
      start(CS_EXT, es[i], 16'h0002, 8'h00);
      period(1'b0, 3 * ep[i], "ext interval");
    end
    start(CS_BAD, 8'h00, 16'h0002, 8'h00);
    repeat (50) @(posedge aclk);
    rd(OFS_COUNTER, d, r);
    check("no tick count", d, 32'h0);
    run_src <= 1'b0;
    $display("Test sources done");
  endtask

  task automatic t_square;
    logic a;
    int t1;
    int t2;
    start(CS_FULL, 8'h00, 16'h0003, 8'h03);
    wait_irq(1'b0, t1);
    a = timer_out;
    wait_irq(1'b0, t2);
    check("half period", t2 - t1, 4);
    check("square toggle", timer_out, !a);
    set(OFS_OUTCTL, 32'h02);
    period(1'b0, 4, "irq output off");
    check("output disabled", timer_out, 1'b0);
    set(OFS_OUTCTL, 32'h01);
    wait_irq(1'b0, t1);
    a = timer_out;
    wait_irq(1'b0, t2);
    check("irq without toggle", t2 - t1, 4);
    check("no toggle", timer_out, a);
    $display("Test square done");
  endtask

  task automatic t_cmp1;
    int t0;
    int t1;
    set(OFS_CMP1, 32'h2);
    start(CS_FULL, 8'h00, 16'h0005, 8'h00);
    period(1'b1, 6, "cmp1 period");
    wait_irq(1'b0, t0);
    wait_irq(1'b1, t1);
    check("cmp1 offset", t1 - t0, 3);
    $display("Test cmp1 done");
  endtask

  task automatic t_read;
    logic [31:0] d1;
    logic [31:0] d2;
    logic [1:0] r;
    int c1;
    start(CS_FULL, 8'h00, 16'h00c8, 8'h00);
    rd(OFS_COUNTER, d1, r);
    c1 = ar_cyc;
    rd(OFS_COUNTER, d2, r);
    check("count advance", d2 - d1, ar_cyc - c1);
    period(1'b0, 201, "interval after reads");
    set(OFS_MODE, 32'h0);
    repeat (5) @(posedge aclk);
    rd(OFS_COUNTER, d1, r);
    check("stopped count", d1, 32'h0);
    set(OFS_MODE, 32'h4);
    rd(OFS_COUNTER, d1, r);
    c1 = ar_cyc;
    rd(OFS_COUNTER, d2, r);
    check("free count", d2 - d1, ar_cyc - c1);
    $display("Test read done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_clocks;
    t_sources;
    t_square;
    t_cmp1;
    t_read;
    finish_test;
  end
endmodule
`default_nettype wire
